// *** rtl/dac_load_and_reset_control.sv ***
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"
module dac_load_and_reset_control (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // asynchronous pins
   input  wire logic                 load_strobe_n_i,
   input  wire logic                 hw_reset_n_i,
   // serial decoder, same clock
   input  wire logic                 bus_start_i,
   input  wire logic                 bus_stop_i,
   input  wire dac_ctrl_pkg::bus_cmd_s bus_cmd_i,
   // converter side
   output logic      [15:0]          dac_code_o,
   output logic      [15:0]          input_reg_o,
   output dac_ctrl_pkg::ctrl_s       ctrl_o,
   output logic                      ref_enable_o,
   // status
   output logic                      bus_access_o,
   output logic                      hw_reset_active_o
);
   import dac_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronizers
   // ----------------------------------------------------------------
   logic [1:0] pins_sync;
   logic       strobe_sync;
   logic       reset_pin_sync;

   // reset pin starts at 0 so power-up counts as "held in reset"
   pin_sync #(
      .WIDTH   (2),
      .RST_VAL (8'h02)
   ) u_pin_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  ({load_strobe_n_i, hw_reset_n_i}),
      .sync_o (pins_sync)
   );

   assign strobe_sync    = pins_sync[1];
   assign reset_pin_sync = pins_sync[0];

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   function automatic logic loads_input(input cmd_e op);
      loads_input = (op == CMD_WR_INPUT) || (op == CMD_WR_BOTH);
   endfunction

   logic        strobe_prev;
   logic        strobe_fall;
   logic        hw_rst_act;
   logic        clear_all;
   logic        cmd_ok;
   logic        load_ok;
   logic        access;
   logic        ref_ready;
   logic [15:0] input_reg;
   logic [15:0] dac_code;
   ctrl_s       ctrl;

   assign hw_rst_act  = ~reset_pin_sync;
   assign strobe_fall = strobe_prev & ~strobe_sync;
   // software reset clears the registers like the pin, one cycle long, but leaves the access window open
   assign clear_all   = hw_rst_act | ctrl.sw_reset;
   assign cmd_ok      = bus_cmd_i.valid & ~hw_rst_act & ~ctrl.sw_reset;
   // a start in the same cycle already counts as an access
   assign load_ok     = strobe_fall & ~access & ~bus_start_i & ~hw_rst_act;

   // ----------------------------------------------------------------
   // edge detector on the synchronized strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_prev <= 1'b1;
      end else begin
         strobe_prev <= strobe_sync;
      end
   end

   // ----------------------------------------------------------------
   // serial access window, start to stop
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || hw_rst_act) begin
         access <= 1'b0;
      end else if (bus_start_i) begin
         access <= 1'b1;
      end else if (bus_stop_i) begin
         access <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // input register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         input_reg <= `DAC_INPUT_RST;
      end else if (cmd_ok && loads_input(bus_cmd_i.op)) begin
         input_reg <= bus_cmd_i.data;
      end
   end

   // ----------------------------------------------------------------
   // dac register; drives the output and stays zero until written
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         dac_code <= `DAC_CODE_RST;
      end else if (cmd_ok && bus_cmd_i.op == CMD_WR_BOTH) begin
         dac_code <= bus_cmd_i.data;
      end else if (cmd_ok && bus_cmd_i.op == CMD_WR_INPUT && !strobe_sync) begin
         dac_code <= bus_cmd_i.data;
      end else if (cmd_ok && bus_cmd_i.op == CMD_UPDATE) begin
         dac_code <= input_reg;
      end else if (load_ok) begin
         dac_code <= input_reg;
      end
   end

   // ----------------------------------------------------------------
   // control register; the reset bit lives one cycle, then clears
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         ctrl <= `DAC_CTRL_RST;
      end else if (cmd_ok && bus_cmd_i.op == CMD_WR_CTRL) begin
         ctrl <= ctrl_s'(bus_cmd_i.data[`CTRL_FIELD_HI:`CTRL_FIELD_LO]);
      end
   end

   // ----------------------------------------------------------------
   // reference start-up waits for the reset pin to go high
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_ready <= 1'b0;
      end else if (!hw_rst_act) begin
         ref_ready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign dac_code_o        = dac_code;
   assign input_reg_o       = input_reg;
   assign ctrl_o            = ctrl;
   assign ref_enable_o      = ref_ready & ~ctrl.ref_off;
   assign bus_access_o      = access;
   assign hw_reset_active_o = hw_rst_act;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // counts cycles of a held reset pin for the cover below
   logic [3:0] rst_low_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !hw_rst_act) begin
         rst_low_cnt <= 4'h0;
      end else if (rst_low_cnt != 4'hf) begin
         rst_low_cnt <= rst_low_cnt + 4'h1;
      end
   end

   a_load_on_fall: assert property (
      (load_ok && !bus_cmd_i.valid && !ctrl.sw_reset) |=> dac_code == $past(input_reg))
      else $error("falling strobe did not load the dac register");

   a_level_no_load: assert property (
      (!strobe_fall && !bus_cmd_i.valid && !clear_all) |=> $stable(dac_code))
      else $error("dac register changed without an edge or command");

   a_access_ignore: assert property (
      (strobe_fall && (access || bus_start_i) && !bus_cmd_i.valid && !clear_all) |=> $stable(dac_code))
      else $error("strobe during access changed the dac register");

   a_reset_zero: assert property (
      hw_rst_act |=> dac_code_o == 16'h0000)
      else $error("hardware reset did not zero the output");

   a_reset_defaults: assert property (
      hw_rst_act |=> (input_reg == 16'h0000) && (ctrl == 5'h00))
      else $error("hardware reset left registers off default");

   a_zero_after_release: assert property (
      $fell(hw_rst_act) |-> dac_code == 16'h0000 ##1
         ($past(bus_cmd_i.valid) || $past(strobe_fall) || dac_code == 16'h0000))
      else $error("output left zero scale after reset release");

   a_cmd_ignored: assert property (
      (hw_rst_act && bus_cmd_i.valid) |=> (input_reg == 16'h0000) && $stable(ctrl))
      else $error("command accepted while reset held");

   a_ref_deferred: assert property (
      (!ref_ready && hw_rst_act) |=> !ref_enable_o)
      else $error("reference enabled while reset held from power-up");

   a_input_only: assert property (
      (cmd_ok && bus_cmd_i.op == CMD_WR_INPUT && strobe_sync) |=>
         (input_reg == $past(bus_cmd_i.data)) && $stable(dac_code))
      else $error("input write disturbed the dac register");

   a_sync_update: assert property (
      (cmd_ok && bus_cmd_i.op == CMD_WR_INPUT && !strobe_sync) |=>
         (dac_code == $past(bus_cmd_i.data)) && (input_reg == dac_code))
      else $error("write with strobe low did not update both registers");

   a_sw_reset_clear: assert property (
      ctrl.sw_reset |=> !ctrl.sw_reset && dac_code == 16'h0000 && input_reg == 16'h0000)
      else $error("software reset bit did not clear itself");

   a_sync_latency: assert property (
      strobe_fall |-> $past(load_strobe_n_i, 2) == 1'b0)
      else $error("strobe edge seen before two synchronizer stages");

   a_access_window: assert property (
      ((bus_start_i || (access && !bus_stop_i)) && !hw_rst_act) |=> access)
      else $error("access window dropped before stop");

   c_async_load: cover property (load_ok ##1 dac_code == input_reg);
   c_strobe_ignored: cover property (strobe_fall && access);
   c_sync_write: cover property (cmd_ok && bus_cmd_i.op == CMD_WR_INPUT && !strobe_sync);
   c_reset_held: cover property (rst_low_cnt == 4'(`HW_RST_MIN_CYC) ##1 !hw_rst_act);

endmodule

// *** rtl/dac_ctrl_defines.svh ***
// Function
// - strobe asserted after completed transfer copies input register to dac register
// - load is triggered by the strobe falling edge, not its level
// - strobe pulse during a serial access is discarded, no transfer
// - hardware reset forces the converter output to zero scale
// - hardware reset returns input, dac and control registers to defaults
// - after reset release output stays zero until a new code is programmed
// - while hardware reset is low every command is ignored
// - reset held through power-up defers reference initialisation until release
// - written data held in input register; separate dac register drives output
// - write with strobe held low updates input, dac and output together
// - software reset bit clears itself to 0 when the reset finishes
`ifndef DAC_CTRL_DEFINES_SVH
`define DAC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// register defaults
// ----------------------------------------------------------------
`define DAC_INPUT_RST  16'h0000
`define DAC_CODE_RST   16'h0000
`define DAC_CTRL_RST   5'h00

// ----------------------------------------------------------------
// control word field positions in the data bytes
// ----------------------------------------------------------------
`define CTRL_FIELD_HI  15
`define CTRL_FIELD_LO  11

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  25
`define HW_RST_MIN_NS  75
`define HW_RST_MIN_CYC ((`HW_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/dac_ctrl_pkg.sv ***
package dac_ctrl_pkg;

   // ----------------------------------------------------------------
   // decoded serial commands
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_WR_INPUT,
      CMD_UPDATE,
      CMD_WR_BOTH,
      CMD_WR_CTRL
   } cmd_e;

   // one command from the serial decoder, valid for one cycle
   typedef struct packed {
      logic        valid;
      cmd_e        op;
      logic [15:0] data;
   } bus_cmd_s;

   // control register, msb first as carried in the data word
   typedef struct packed {
      logic       sw_reset;
      logic [1:0] power_down;
      logic       ref_off;
      logic       gain;
   } ctrl_s;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
   parameter int         WIDTH   = 1,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // pins and synchronized levels
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   // ----------------------------------------------------------------
   // two flops; stage1 feeds stage2 only, to contain metastability
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= RST_VAL[WIDTH-1:0];
         sync_o <= RST_VAL[WIDTH-1:0];
      end else begin
         stage1 <= pin_i;
         sync_o <= stage1;
      end
   end

endmodule

// *** test/dac_host_model.sv ***
`timescale 1ns/1ps
module dac_host_model (
   // clock
   input  wire logic             clk_i,
   // pins and serial decoder side
   output logic                  load_strobe_n_o,
   output logic                  hw_reset_n_o,
   output logic                  bus_start_o,
   output logic                  bus_stop_o,
   output dac_ctrl_pkg::bus_cmd_s bus_cmd_o
);
   import dac_ctrl_pkg::*;

   // strobe idles high, reset pin held low from power-up
   initial begin
      load_strobe_n_o = 1'b1;
      hw_reset_n_o    = 1'b0;
      bus_start_o     = 1'b0;
      bus_stop_o      = 1'b0;
      bus_cmd_o       = '0;
   end

   // one decoded command; data inverted after, so a stale word never matches
   task automatic send_cmd(input cmd_e op, input logic [15:0] data);
      @(posedge clk_i) #1;
      bus_cmd_o = '{valid: 1'b1, op: op, data: data};
      @(posedge clk_i) #1;
      bus_cmd_o.valid = 1'b0;
      bus_cmd_o.data  = ~data;
   endtask

   // start or stop condition, one cycle
   task automatic pulse_cond(input logic stop);
      @(posedge clk_i) #1;
      bus_start_o = ~stop;
      bus_stop_o  = stop;
      @(posedge clk_i) #1;
      bus_start_o = 1'b0;
      bus_stop_o  = 1'b0;
   endtask

   // whole transfer framed by start and stop
   task automatic write(input cmd_e op, input logic [15:0] data);
      pulse_cond(1'b0);
      send_cmd(op, data);
      pulse_cond(1'b1);
   endtask

   // strobe level; lowered after stop except where a scenario breaks that
   task automatic set_strobe(input logic lvl);
      @(posedge clk_i) #1;
      load_strobe_n_o = lvl;
   endtask

   // reset pulse, never shorter than three cycles (75 ns)
   task automatic hw_pulse(input int cyc);
      @(posedge clk_i) #1;
      hw_reset_n_o = 1'b0;
      repeat ((cyc < 3) ? 3 : cyc) @(posedge clk_i);
      #1;
      hw_reset_n_o = 1'b1;
   endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import dac_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // clock, reset and wiring
   // ----------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        load_strobe_n, hw_reset_n, bus_start, bus_stop;
   bus_cmd_s    bus_cmd;
   logic [15:0] dac_code, input_reg, exp_in, exp_dac, d;
   ctrl_s       ctrl;
   logic        ref_enable, bus_access, hw_reset_active;
   int          err_count = 0;
   int          checked   = 0;

   always #12.5 clk_i = ~clk_i;

   dac_host_model u_dac_host_model (.clk_i(clk_i), .load_strobe_n_o(load_strobe_n), .hw_reset_n_o(hw_reset_n),
      .bus_start_o(bus_start), .bus_stop_o(bus_stop), .bus_cmd_o(bus_cmd));

   dac_load_and_reset_control u_dac_load_and_reset_control (.clk_i(clk_i), .rst_i(rst_i),
      .load_strobe_n_i(load_strobe_n), .hw_reset_n_i(hw_reset_n), .bus_start_i(bus_start),
      .bus_stop_i(bus_stop), .bus_cmd_i(bus_cmd), .dac_code_o(dac_code), .input_reg_o(input_reg),
      .ctrl_o(ctrl), .ref_enable_o(ref_enable), .bus_access_o(bus_access),
      .hw_reset_active_o(hw_reset_active));

   // ----------------------------------------------------------------
   // compares and closing
   // ----------------------------------------------------------------
   task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_regs(input logic [15:0] i, input logic [15:0] dc);
      chk16("input_reg", i, input_reg);
      chk16("dac_code", dc, dac_code);
   endtask

   task automatic finish_test();
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      err_count++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      d = 16'($urandom(91));
      repeat (5) @(posedge clk_i);
      #1 rst_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      chk1("ref_enable", 1'b0, ref_enable);
      chk1("hw_reset_active", 1'b1, hw_reset_active);
      u_dac_host_model.hw_pulse(0);
      repeat (4) @(posedge clk_i);
      #1;
      chk1("ref_enable", 1'b1, ref_enable);
      exp_in  = 16'h0000;
      exp_dac = 16'h0000;
      check_regs(exp_in, exp_dac);
      // random codes loaded by a strobe fall after the stop
      repeat (20) begin
         d = 16'($urandom);
         u_dac_host_model.write(CMD_WR_INPUT, d);
         exp_in = d;
         check_regs(exp_in, exp_dac);
         repeat ($urandom_range(3)) @(posedge clk_i);
         u_dac_host_model.set_strobe(1'b0);
         repeat (3) @(posedge clk_i);
         #1;
         exp_dac = exp_in;
         check_regs(exp_in, exp_dac);
         u_dac_host_model.set_strobe(1'b1);
      end
      // write with strobe held low updates both at once
      u_dac_host_model.set_strobe(1'b0);
      d = 16'($urandom);
      u_dac_host_model.write(CMD_WR_INPUT, d);
      exp_in  = d;
      exp_dac = d;
      check_regs(exp_in, exp_dac);
      u_dac_host_model.set_strobe(1'b1);
      // strobe pulse and fall inside an access, still low after stop
      d = ~d;
      u_dac_host_model.pulse_cond(1'b0);
      u_dac_host_model.send_cmd(CMD_WR_INPUT, d);
      exp_in = d;
      chk1("bus_access", 1'b1, bus_access);
      u_dac_host_model.set_strobe(1'b0);
      u_dac_host_model.set_strobe(1'b1);
      u_dac_host_model.set_strobe(1'b0);
      repeat (3) @(posedge clk_i);
      u_dac_host_model.pulse_cond(1'b1);
      repeat (4) @(posedge clk_i);
      #1;
      chk1("bus_access", 1'b0, bus_access);
      check_regs(exp_in, exp_dac);
      u_dac_host_model.set_strobe(1'b1);
      // remaining commands
      d = 16'($urandom);
      u_dac_host_model.write(CMD_WR_BOTH, d);
      check_regs(d, d);
      u_dac_host_model.write(CMD_WR_INPUT, ~d);
      u_dac_host_model.write(CMD_NOP, 16'h1234);
      check_regs(~d, d);
      u_dac_host_model.write(CMD_UPDATE, 16'h0000);
      check_regs(~d, ~d);
      for (int v = 0; v < 16; v++) begin
         u_dac_host_model.write(CMD_WR_CTRL, {1'b0, 4'(v), 11'h000});
         chk16("ctrl", 16'(v), 16'(ctrl));
         chk1("ref_enable", ~v[1], ref_enable);
      end
      // software reset clears itself and the registers
      u_dac_host_model.write(CMD_WR_CTRL, 16'h8000);
      check_regs(16'h0000, 16'h0000);
      chk16("ctrl", 16'h0000, 16'(ctrl));
      // hardware reset with a command dropped while it is low
      u_dac_host_model.write(CMD_WR_BOTH, d);
      u_dac_host_model.write(CMD_WR_CTRL, 16'h0800);
      fork
         u_dac_host_model.hw_pulse(10);
         begin
            repeat (5) @(posedge clk_i);
            #1;
            chk1("hw_reset_active", 1'b1, hw_reset_active);
            check_regs(16'h0000, 16'h0000);
            u_dac_host_model.write(CMD_WR_BOTH, d);
         end
      join
      repeat (4) @(posedge clk_i);
      #1;
      chk1("hw_reset_active", 1'b0, hw_reset_active);
      chk16("ctrl", 16'h0000, 16'(ctrl));
      check_regs(16'h0000, 16'h0000);
      u_dac_host_model.write(CMD_WR_INPUT, d);
      check_regs(d, 16'h0000);
      finish_test();
   end
endmodule
